/* common/pscl_defs.svh */
// Timing, count and field constants of the serial configuration loader
`ifndef PSCL_DEFS_SVH
`define PSCL_DEFS_SVH

// ----------------------------------------------------------------------
// System clock
// ----------------------------------------------------------------------
`define PSCL_CLK_MHZ 40
`define PSCL_CLK_PERIOD_NS 25

// ----------------------------------------------------------------------
// Reconfiguration handshake times
// ----------------------------------------------------------------------
`define PSCL_T_CF2CD_LIM_NS 600
`define PSCL_T_CF2ST0_LIM_NS 600
`define PSCL_T_CFG_MIN_US 2
`define PSCL_T_STATUS_MIN_US 268
`define PSCL_T_STATUS_LIM_US 1506
`define PSCL_T_CF2ST1_LIM_US 1506
`define PSCL_T_ST2CK_MIN_US 2

// ----------------------------------------------------------------------
// Initialization
// ----------------------------------------------------------------------
`define PSCL_T_CD2UM_MIN_US 175
`define PSCL_T_CD2UM_LIM_US 437
`define PSCL_SCLK_LIM_MHZ 125
`define PSCL_CD2CU_PERIODS 4
`define PSCL_INIT_CLKS 8576
`define PSCL_TRAIL_FALLS 2

// ----------------------------------------------------------------------
// Remote upgrade strobes
// ----------------------------------------------------------------------
`define PSCL_T_STROBE_MIN_NS 250

// ----------------------------------------------------------------------
// Option bits at the head of the bitstream, first bit received is bit 0
// ----------------------------------------------------------------------
`define PSCL_OPT_W 3
`define PSCL_OPT_INIT_DONE_EN 0
`define PSCL_OPT_SRC_LSB 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PSCL_RST_STATUS_OE 1'b1
`define PSCL_RST_DONE 1'b0

`endif

/* common/pscl_pkg.sv */
// Types shared by the serial configuration loader
package pscl_pkg;

  // Initialization clock source, as loaded from the option bits
  typedef enum logic [1:0] {
    PSCL_SRC_OSC,
    PSCL_SRC_USR,
    PSCL_SRC_SCLK
  } pscl_src_e;

  typedef enum logic [2:0] {
    PSCL_ST_CLEAR,
    PSCL_ST_WAIT,
    PSCL_ST_SHIFT,
    PSCL_ST_TRAIL,
    PSCL_ST_INIT,
    PSCL_ST_USER
  } pscl_state_e;

  typedef struct packed {
    logic init_done_en;
    pscl_src_e src;
  } pscl_opt_s;

  // Synchronised pin group
  typedef struct packed {
    logic status_n;
    logic usr_clk;
    logic data;
    logic sclk;
    logic req_n;
  } pscl_pins_s;

endpackage

/* rtl/pscl_sync.sv */
// Two-stage pin synchroniser with edge detection
`timescale 1ns/10ps
module pscl_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_d;
  logic [W-1:0] s3_d;

  always_comb begin
    s1_d = ce_i ? d_i : s1_q;
    s2_d = ce_i ? s1_q : s2_q;
    s3_d = ce_i ? s2_q : s3_q;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // Edges are seen only from the second and third stages
  assign q_o = s2_q;
  assign rise_o = s2_q & ~s3_q;
  assign fall_o = ~s2_q & s3_q;

endmodule

/* rtl/pscl_wdog.sv */
// User watchdog: expires unless kicked within its period
`timescale 1ns/10ps
module pscl_wdog #(
  parameter int CYC = 4000000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic kick_i,
  output logic expire_o
);

  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic exp_q;
  logic exp_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (!en_i || kick_i) begin
      cnt_d = '0;
    end else if (cnt_q >= 32'(CYC - 1)) begin
      cnt_d = '0;
      exp_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expire_o = exp_q;

endmodule

/* rtl/pscl_loader.sv */
// Passive serial configuration loader, device side
// Behaviour
// - user mode: pins high; request low reconfigures
// - status low through power-on delay
// - done low until configuration completes
// - done high only after full bitstream
// - done low within 600 ns of request
// - status low within 600 ns of request
// - status low 268 to 1506 us
// - status released within 1506 us after request
// - data captured on serial clock rise
// - oscillator init: user mode 175-437 us
// - user clock enabled, then 8576 cycles
// - three selectable initialization clock sources
// - init pin low until initialization ends
`include "pscl_defs.svh"
`timescale 1ns/10ps
module pscl_loader #(
  parameter int CFG_BITS = 64,
  parameter int ST_MIN_CYC =
    `PSCL_T_STATUS_MIN_US * `PSCL_CLK_MHZ,
  parameter int OSC_CYC =
    `PSCL_T_CD2UM_MIN_US * `PSCL_CLK_MHZ,
  parameter int INIT_CLKS = `PSCL_INIT_CLKS,
  parameter int WDOG_CYC = 4000000
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic config_request_n_i,
  input wire logic config_serial_clock_i,
  input wire logic serial_config_data_i,
  input wire logic user_startup_clock_i,
  input wire logic status_n_i,
  input wire logic reconfig_request_i,
  input wire logic watchdog_reset_strobe_i,
  input wire logic watchdog_en_i,
  output logic status_n_o,
  output logic status_n_oe_o,
  output logic config_done_o,
  output logic init_complete_o,
  output logic init_complete_oe_o,
  output logic user_clk_en_o,
  output logic user_mode_o,
  output pscl_pkg::pscl_opt_s options_o
);

  // --------------------------------------------------------------------
  // Derived counts
  // --------------------------------------------------------------------
  localparam int SCLK_MIN_NS = 1000 / `PSCL_SCLK_LIM_MHZ;
  localparam int CU_NS = `PSCL_CD2CU_PERIODS * SCLK_MIN_NS;
  localparam int CU_CYC_RAW =
    (CU_NS + `PSCL_CLK_PERIOD_NS - 1) / `PSCL_CLK_PERIOD_NS;
  localparam int CU_CYC = (CU_CYC_RAW < 1) ? 1 : CU_CYC_RAW;
  localparam int CW = 24;
  localparam int EW = 16;
  localparam int OW = `PSCL_OPT_W;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  pscl_pkg::pscl_pins_s pin_raw;
  pscl_pkg::pscl_pins_s pin_lvl;
  pscl_pkg::pscl_pins_s pin_rise;
  pscl_pkg::pscl_pins_s pin_fall;

  always_comb begin
    pin_raw.status_n = status_n_i;
    pin_raw.usr_clk = user_startup_clock_i;
    pin_raw.data = serial_config_data_i;
    pin_raw.sclk = config_serial_clock_i;
    pin_raw.req_n = config_request_n_i;
  end

  pscl_sync #(
    .W($bits(pscl_pkg::pscl_pins_s))
  ) u_sync (
    .clk_i(mclk_i),
    .rst_i(sys_rst_i),
    .ce_i(ce_i),
    .d_i(pin_raw),
    .q_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  pscl_pkg::pscl_state_e st_q;
  pscl_pkg::pscl_state_e st_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [EW-1:0] ecnt_q;
  logic [EW-1:0] ecnt_d;
  logic [31:0] bits_q;
  logic [31:0] bits_d;
  logic [OW-1:0] osr_q;
  logic [OW-1:0] osr_d;
  logic [OW-1:0] osr_next;
  pscl_pkg::pscl_opt_s opt_q;
  pscl_pkg::pscl_opt_s opt_d;
  logic stat_oe_q;
  logic stat_oe_d;
  logic done_q;
  logic done_d;
  logic ic_q;
  logic ic_d;
  logic ic_oe_q;
  logic ic_oe_d;
  logic clken_q;
  logic clken_d;
  logic umode_q;
  logic umode_d;
  logic rc_prev_q;
  logic rc_rise;
  logic wd_expire;
  logic restart;
  logic init_edge;
  logic init_end;

  // --------------------------------------------------------------------
  // Remote upgrade triggers
  // --------------------------------------------------------------------
  pscl_wdog #(
    .CYC(WDOG_CYC)
  ) u_wdog (
    .clk_i(mclk_i),
    .rst_i(sys_rst_i),
    .ce_i(ce_i),
    .en_i(umode_q & watchdog_en_i),
    .kick_i(watchdog_reset_strobe_i),
    .expire_o(wd_expire)
  );

  assign rc_rise = reconfig_request_i & ~rc_prev_q;

  // Request low outside the clearing phase restarts at once
  always_comb begin
    restart = ((~pin_lvl.req_n) && (st_q != pscl_pkg::PSCL_ST_CLEAR))
      || rc_rise || wd_expire;
  end

  // Edge that clocks the initialization count
  always_comb begin
    osr_next = {pin_lvl.data, osr_q[OW-1:1]};
    case (opt_q.src)
      pscl_pkg::PSCL_SRC_USR: init_edge = clken_q & pin_rise.usr_clk;
      pscl_pkg::PSCL_SRC_SCLK: init_edge = pin_rise.sclk;
      default: init_edge = 1'b0;
    endcase
    case (opt_q.src)
      pscl_pkg::PSCL_SRC_USR,
      pscl_pkg::PSCL_SRC_SCLK: begin
        init_end = init_edge && (ecnt_q == EW'(INIT_CLKS - 1));
      end
      default: begin
        init_end = cnt_q >= CW'(OSC_CYC - 1);
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    ecnt_d = ecnt_q;
    bits_d = bits_q;
    osr_d = osr_q;
    opt_d = opt_q;
    stat_oe_d = stat_oe_q;
    done_d = done_q;
    ic_d = ic_q;
    ic_oe_d = ic_oe_q;
    clken_d = clken_q;
    umode_d = umode_q;
    if (restart) begin
      st_d = pscl_pkg::PSCL_ST_CLEAR;
      cnt_d = '0;
      ecnt_d = '0;
      bits_d = '0;
      stat_oe_d = 1'b1;
      done_d = 1'b0;
      ic_d = 1'b0;
      ic_oe_d = 1'b0;
      clken_d = 1'b0;
      umode_d = 1'b0;
    end else begin
      case (st_q)
        pscl_pkg::PSCL_ST_CLEAR: begin
          stat_oe_d = 1'b1;
          done_d = 1'b0;
          if (cnt_q != {CW{1'b1}}) begin
            cnt_d = cnt_q + CW'(1);
          end
          if (pin_lvl.req_n && (cnt_q >= CW'(ST_MIN_CYC - 1))) begin
            st_d = pscl_pkg::PSCL_ST_WAIT;
            stat_oe_d = 1'b0;
          end
        end
        pscl_pkg::PSCL_ST_WAIT: begin
          // Stays while something outside holds status low
          if (pin_lvl.status_n) begin
            st_d = pscl_pkg::PSCL_ST_SHIFT;
          end
        end
        pscl_pkg::PSCL_ST_SHIFT: begin
          if (!pin_lvl.status_n) begin
            st_d = pscl_pkg::PSCL_ST_CLEAR;
            cnt_d = '0;
            bits_d = '0;
            stat_oe_d = 1'b1;
          end else if (pin_rise.sclk) begin
            bits_d = bits_q + 32'h1;
            if (bits_q < 32'(OW)) begin
              osr_d = osr_next;
            end
            if (bits_q == 32'(OW - 1)) begin
              opt_d.init_done_en = osr_next[`PSCL_OPT_INIT_DONE_EN];
              opt_d.src = pscl_pkg::pscl_src_e'(
                osr_next[`PSCL_OPT_SRC_LSB +: 2]);
              ic_d = 1'b0;
              ic_oe_d = osr_next[`PSCL_OPT_INIT_DONE_EN];
            end
            if (bits_q == 32'(CFG_BITS - 1)) begin
              st_d = pscl_pkg::PSCL_ST_TRAIL;
              done_d = 1'b1;
              ecnt_d = '0;
            end
          end
        end
        pscl_pkg::PSCL_ST_TRAIL: begin
          if (pin_fall.sclk) begin
            ecnt_d = ecnt_q + EW'(1);
            if (ecnt_q == EW'(`PSCL_TRAIL_FALLS - 1)) begin
              st_d = pscl_pkg::PSCL_ST_INIT;
              cnt_d = '0;
              ecnt_d = '0;
            end
          end
        end
        pscl_pkg::PSCL_ST_INIT: begin
          if (cnt_q != {CW{1'b1}}) begin
            cnt_d = cnt_q + CW'(1);
          end
          if (opt_q.src == pscl_pkg::PSCL_SRC_USR &&
              cnt_q >= CW'(CU_CYC - 1)) begin
            clken_d = 1'b1;
          end
          if (init_edge) begin
            ecnt_d = ecnt_q + EW'(1);
          end
          if (init_end) begin
            st_d = pscl_pkg::PSCL_ST_USER;
            umode_d = 1'b1;
            clken_d = 1'b0;
            ic_d = 1'b1;
            ic_oe_d = 1'b0;
          end
        end
        pscl_pkg::PSCL_ST_USER: begin
          umode_d = 1'b1;
          stat_oe_d = 1'b0;
          done_d = 1'b1;
        end
        default: begin
          st_d = pscl_pkg::PSCL_ST_CLEAR;
          cnt_d = '0;
          stat_oe_d = 1'b1;
          done_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= pscl_pkg::PSCL_ST_CLEAR;
      cnt_q <= '0;
      ecnt_q <= '0;
      bits_q <= '0;
      osr_q <= '0;
      opt_q <= '0;
      stat_oe_q <= `PSCL_RST_STATUS_OE;
      done_q <= `PSCL_RST_DONE;
      ic_q <= 1'b0;
      ic_oe_q <= 1'b0;
      clken_q <= 1'b0;
      umode_q <= 1'b0;
      rc_prev_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ecnt_q <= ecnt_d;
      bits_q <= bits_d;
      osr_q <= osr_d;
      opt_q <= opt_d;
      stat_oe_q <= stat_oe_d;
      done_q <= done_d;
      ic_q <= ic_d;
      ic_oe_q <= ic_oe_d;
      clken_q <= clken_d;
      umode_q <= umode_d;
      rc_prev_q <= reconfig_request_i;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Status is open drain: only ever pulled low
  assign status_n_o = 1'b0;
  assign status_n_oe_o = stat_oe_q;
  assign config_done_o = done_q;
  assign init_complete_o = ic_q;
  assign init_complete_oe_o = ic_oe_q;
  assign user_clk_en_o = clken_q;
  assign user_mode_o = umode_q;
  assign options_o = opt_q;

endmodule

/* sim/pscl_loader_asserts.sv */
// Port checker for the serial configuration loader
`timescale 1ns/10ps
module pscl_loader_asserts #(
  parameter int ST_MIN_CYC = 40,
  parameter int OSC_CYC = 20
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic config_request_n_i,
  input wire logic reconfig_request_i,
  input wire logic status_n_oe_o,
  input wire logic config_done_o,
  input wire logic init_complete_o,
  input wire logic init_complete_oe_o,
  input wire logic user_clk_en_o,
  input wire logic user_mode_o,
  input wire pscl_pkg::pscl_opt_s options_o
);
  localparam int OSC_HI = OSC_CYC * 3 + 40;
  int st_q, st_d, dn_q, dn_d;
  // --------------------
  // Cycle counters
  // --------------------
  always_comb begin
    st_d = status_n_oe_o ? st_q + 1 : 0;
    dn_d = (config_done_o && !user_mode_o) ? dn_q + 1 : 0;
  end
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= 0;
      dn_q <= 0;
    end else begin
      st_q <= st_d;
      dn_q <= dn_d;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  done_on_req_a: assert property ($fell(config_request_n_i) |->
    ##[1:24] !config_done_o) else $error("done not low after request");
  stat_on_req_a: assert property ($fell(config_request_n_i) |->
    ##[1:24] status_n_oe_o) else $error("status not low after request");
  stat_min_a: assert property ($fell(status_n_oe_o) |->
    st_q >= ST_MIN_CYC) else $error("status low too short");
  user_pins_a: assert property (user_mode_o |-> config_done_o &&
    !status_n_oe_o && !init_complete_oe_o) else $error("user mode pins");
  done_low_cfg_a: assert property (status_n_oe_o &&
    $past(status_n_oe_o) |-> !config_done_o) else $error("done high early");
  done_rise_a: assert property ($rose(config_done_o) |->
    !status_n_oe_o && !user_mode_o) else $error("done rose in reset phase");
  osc_time_a: assert property ($rose(user_mode_o) &&
    options_o.src == pscl_pkg::PSCL_SRC_OSC |-> dn_q inside {[OSC_CYC:OSC_HI]})
    else $error("oscillator init time out of range");
  clk_en_src_a: assert property (user_clk_en_o |->
    options_o.src == pscl_pkg::PSCL_SRC_USR && config_done_o && !user_mode_o)
    else $error("user clock enable wrong");
  init_pin_a: assert property (init_complete_oe_o |->
    !init_complete_o && !user_mode_o) else $error("init pin wrong");
  remote_req_a: assert property ($rose(reconfig_request_i) &&
    user_mode_o |-> ##[1:3] status_n_oe_o) else $error("strobe ignored");
  cover property ($rose(user_mode_o));
  cover property ($rose(user_clk_en_o));
  cover property ($fell(config_done_o));
endmodule
bind pscl_loader pscl_loader_asserts #(.ST_MIN_CYC(ST_MIN_CYC),
  .OSC_CYC(OSC_CYC)) u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .config_request_n_i(config_request_n_i),
  .reconfig_request_i(reconfig_request_i), .status_n_oe_o(status_n_oe_o),
  .config_done_o(config_done_o), .init_complete_o(init_complete_o),
  .init_complete_oe_o(init_complete_oe_o), .user_clk_en_o(user_clk_en_o),
  .user_mode_o(user_mode_o), .options_o(options_o));

/* sim/pscl_host.sv */
// Model of the external configuration host
`timescale 1ns/10ps
module pscl_host (
  input wire logic mclk_i,
  input wire logic status_i,
  output logic req_n_o,
  output logic sclk_o,
  output logic data_o,
  output logic usr_clk_o,
  output logic pull_o
);
  // --------------------
  // Pin drivers
  // --------------------
  initial begin
    req_n_o = 1'b1;
    sclk_o = 1'b0;
    data_o = 1'b0;
    usr_clk_o = 1'b0;
    pull_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic req(input logic lvl);
    @(posedge mclk_i);
    req_n_o <= lvl;
  endtask
  task automatic settle();
    tick(80);
  endtask
  task automatic send(input logic [7:0] b, input int n);
    @(posedge mclk_i);
    for (int i = 0; i < n; i++) begin
      sclk_o <= 1'b0;
      data_o <= b[i];
      tick(4);
      sclk_o <= 1'b1;
      tick(4);
    end
    data_o <= ~b[n-1];
  endtask
  task automatic clocks(input int n);
    @(posedge mclk_i);
    repeat (n) begin
      sclk_o <= 1'b0;
      tick(4);
      sclk_o <= 1'b1;
      tick(4);
    end
  endtask
  task automatic usr(input int n);
    @(posedge mclk_i);
    repeat (n) begin
      usr_clk_o <= 1'b1;
      tick(4);
      usr_clk_o <= 1'b0;
      tick(4);
    end
  endtask
  task automatic pull(input logic lvl);
    @(posedge mclk_i);
    pull_o <= lvl;
  endtask
endmodule

/* sim/pscl_loader_bench.sv */
// Self-checking bench of the serial configuration loader
`timescale 1ns/10ps
module pscl_loader_bench;
  logic mclk_i, sys_rst_i, reconf, wd_kick, wd_en, ce;
  logic req_n, sclk, data, usr_clk, pull;
  logic st_oe, done, ic, ic_oe, clk_en, umode;
  pscl_pkg::pscl_opt_s opts;
  wire logic status_w;
  int fails = 0;
  int checks = 0;
  assign status_w = !st_oe && !pull;
  pscl_loader #(.CFG_BITS(8), .ST_MIN_CYC(40), .OSC_CYC(20), .INIT_CLKS(8),
    .WDOG_CYC(200)) dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce),
    .config_request_n_i(req_n), .config_serial_clock_i(sclk),
    .serial_config_data_i(data), .user_startup_clock_i(usr_clk),
    .status_n_i(status_w), .reconfig_request_i(reconf),
    .watchdog_reset_strobe_i(wd_kick), .watchdog_en_i(wd_en),
    .status_n_o(), .status_n_oe_o(st_oe), .config_done_o(done),
    .init_complete_o(ic), .init_complete_oe_o(ic_oe),
    .user_clk_en_o(clk_en), .user_mode_o(umode), .options_o(opts));
  pscl_host host (.mclk_i(mclk_i), .status_i(status_w), .req_n_o(req_n),
    .sclk_o(sclk), .data_o(data), .usr_clk_o(usr_clk), .pull_o(pull));
  // --------------------
  // Shared tasks
  // --------------------
  task automatic test_done();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    #1;
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_on(input int sel, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 4000) begin
      @(posedge mclk_i);
      #1;
      n++;
      case (sel)
        0: hit = (status_w === 1'b1);
        1: hit = (done === 1'b1);
        2: hit = (umode === 1'b1);
        default: hit = (clk_en === 1'b1);
      endcase
    end
  endtask
  task automatic restart();
    int n;
    host.req(1'b0);
    host.tick(24);
    chk(st_oe, 1'b1);
    chk(done, 1'b0);
    host.tick(56);
    host.req(1'b1);
    wait_on(0, n);
    chk(n < 80, 1'b1);
    host.settle();
  endtask
  task automatic cfg(input logic [7:0] b, input logic [2:0] o);
    int n;
    restart();
    host.send(b, 7);
    chk(done, 1'b0);
    host.send(b >> 7, 1);
    wait_on(1, n);
    chk(n <= 8, 1'b1);
    chk(opts, o);
    chk(ic_oe, o[2]);
  endtask
  // --------------------
  // Scenarios
  // --------------------
  task automatic t_power();
    int n;
    chk(st_oe, 1'b1);
    wait_on(0, n);
    chk(n >= 40, 1'b1);
    $display("test power done");
  endtask
  task automatic t_osc();
    time t0;
    int n;
    cfg(8'ha1, 3'b100);
    t0 = $time;
    host.clocks(2);
    wait_on(2, n);
    // Window of 20 to 49 clock periods after done rises
    chk(($time - t0) >= 64'h1f4, 1'b1);
    chk(($time - t0) <= 64'h4c9, 1'b1);
    chk(ic, 1'b1);
    chk(status_w & done, 1'b1);
    $display("test oscillator init done");
  endtask
  task automatic t_usr();
    int n;
    cfg(8'h53, 3'b101);
    host.clocks(2);
    wait_on(3, n);
    chk(clk_en, 1'b1);
    host.usr(7);
    chk(umode, 1'b0);
    host.usr(1);
    wait_on(2, n);
    chk(n <= 8, 1'b1);
    chk(clk_en, 1'b0);
    $display("test user clock init done");
  endtask
  task automatic t_sclk();
    int n;
    cfg(8'h04, 3'b010);
    host.clocks(2);
    host.clocks(8);
    wait_on(2, n);
    chk(umode, 1'b1);
    $display("test serial clock init done");
  endtask
  task automatic t_abort();
    restart();
    host.send(8'ha1, 4);
    host.pull(1'b1);
    host.tick(8);
    chk(st_oe, 1'b1);
    host.pull(1'b0);
    chk(done, 1'b0);
    $display("test abort done");
  endtask
  task automatic t_remote();
    t_osc();
    @(posedge mclk_i);
    reconf <= 1'b1;
    host.tick(10);
    reconf <= 1'b0;
    chk(st_oe, 1'b1);
    t_osc();
    @(posedge mclk_i);
    wd_en <= 1'b1;
    repeat (4) begin
      host.tick(150);
      wd_kick <= 1'b1;
      host.tick(10);
      wd_kick <= 1'b0;
    end
    chk(umode, 1'b1);
    // Clock enable low must freeze the watchdog count
    host.tick(100);
    ce <= 1'b0;
    host.tick(150);
    ce <= 1'b1;
    chk(umode, 1'b1);
    host.tick(120);
    wd_en <= 1'b0;
    chk(st_oe, 1'b1);
    $display("test remote done");
  endtask
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  initial begin
    #500000;
    fails++;
    test_done();
  end
  initial begin
    sys_rst_i = 1'b1;
    reconf = 1'b0;
    wd_kick = 1'b0;
    wd_en = 1'b0;
    ce = 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_power();
    t_osc();
    t_usr();
    t_sclk();
    t_abort();
    t_remote();
    test_done();
  end
endmodule
